// ==== pkg/effl_cfg.svh ====
// constants for the ethernet frame format logic: field sizes, values, timing
// assumes the includer wants plain `define macros, no processes
`ifndef EFFL_CFG_SVH
`define EFFL_CFG_SVH
`define EFFL_PREAMBLE_BYTE 8'hAA
`define EFFL_PREAMBLE_LEN 7
`define EFFL_SFD_BYTE 8'hAB
`define EFFL_ADDR_LEN 6
`define EFFL_MAX_LEN 16'h05DC
`define EFFL_MIN_TYPE 16'h0600
`define EFFL_MIN_DATA 46
`define EFFL_FCS_LEN 4
`define EFFL_CRC_POLY 32'hEDB8_8320
`define EFFL_CRC_PRESET 32'hFFFF_FFFF
`define EFFL_CRC_RESIDUE 32'hDEBB_20E3
`define EFFL_IFG_BITS 96
`define EFFL_IFG_BYTES 12
`endif

// ==== pkg/effl_pkg.sv ====
// types shared by the ethernet frame format logic
// assumes the cfg header holds every number
package effl_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE = 3'b001,
    TX_SFD = 3'b010,
    TX_BODY = 3'b011,
    TX_PAD = 3'b100,
    TX_FCS = 3'b101,
    TX_GAP = 3'b110
  } effl_tx_e;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_DATA = 2'b01,
    RX_DROP = 2'b10
  } effl_rx_e;
  typedef enum logic [1:0] {
    DA_INDIV = 2'b00,
    DA_MULTI = 2'b01,
    DA_BCAST = 2'b10
  } effl_da_e;
endpackage

// ==== logic/effl_crc.sv ====
// byte-wide ethernet crc-32 register, reflected form
// assumes clear and update never come in the same cycle
`include "effl_cfg.svh"
`timescale 1ns/100ps
module effl_crc (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic update,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  // one byte through the lfsr, lsb first as on the wire
  function automatic logic [31:0] crcByte(input logic [31:0] c,
                                          input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `EFFL_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // all-ones preset so leading zeros are not invisible
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      crc <= `EFFL_CRC_PRESET;
    end else if (update) begin
      crc <= crcByte(crc, data);
    end
  end
endmodule

// ==== logic/effl_frame.sv ====
// ethernet frame assembly and checking on a byte stream
// assumes the phy side is byte wide, one strobe per byte, on clk
`include "effl_cfg.svh"
`timescale 1ns/100ps
module effl_frame import effl_pkg::*; #(
  parameter int BYTE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady,
  output logic [7:0] lineTxData,
  output logic lineTxEn,
  input wire logic lineRxDv,
  input wire logic [7:0] lineRxData,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxStart,
  output logic rxGood,
  output logic rxBad,
  output logic [1:0] rxAddrKind,
  output logic rxIsType,
  output logic [15:0] rxLenType
);
  // byte pacing: one line byte per BYTE_CYCLES clocks
  logic [15:0] paceCnt_reg;
  logic tick;
  always_ff @(posedge clk) begin
    if (!resetn || tick) begin
      paceCnt_reg <= '0;
    end else begin
      paceCnt_reg <= paceCnt_reg + 16'h0001;
    end
  end
  assign tick = (paceCnt_reg == 16'(BYTE_CYCLES - 1));

  // transmit side
  effl_tx_e txState_reg;
  logic [10:0] txCnt_reg;
  logic [1:0] fcsIdx_reg;
  logic [31:0] txCrc;
  logic txCrcClr;
  logic txCrcUpd;
  logic [7:0] txByte;
  logic inBody;
  logic dataDone;

  assign inBody = (txState_reg == TX_BODY);
  // user byte is taken only on a body tick, so the stall is honest
  assign txReady = inBody && tick;
  assign dataDone = (txCnt_reg >= 11'(2 * `EFFL_ADDR_LEN + 2
                                     + `EFFL_MIN_DATA - 1));

  // state and byte counter
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txState_reg <= TX_IDLE;
      txCnt_reg <= '0;
      fcsIdx_reg <= '0;
    end else if (tick) begin
      unique case (txState_reg)
        TX_IDLE: begin
          txCnt_reg <= '0;
          if (txValid) begin
            txState_reg <= TX_PRE;
          end
        end
        TX_PRE: begin
          txCnt_reg <= txCnt_reg + 11'd1;
          if (txCnt_reg == 11'(`EFFL_PREAMBLE_LEN - 1)) begin
            txState_reg <= TX_SFD;
          end
        end
        TX_SFD: begin
          txCnt_reg <= '0;
          txState_reg <= TX_BODY;
        end
        TX_BODY: begin
          // a user stall mid frame would underrun; pad zeros then
          txCnt_reg <= txCnt_reg + 11'd1;
          if (txValid && txLast || !txValid) begin
            fcsIdx_reg <= '0;
            txState_reg <= dataDone ? TX_FCS : TX_PAD;
          end
        end
        TX_PAD: begin
          txCnt_reg <= txCnt_reg + 11'd1;
          if (dataDone) begin
            txState_reg <= TX_FCS;
          end
        end
        TX_FCS: begin
          fcsIdx_reg <= fcsIdx_reg + 2'd1;
          txCnt_reg <= '0;
          if (fcsIdx_reg == 2'(`EFFL_FCS_LEN - 1)) begin
            txState_reg <= TX_GAP;
          end
        end
        TX_GAP: begin
          txCnt_reg <= txCnt_reg + 11'd1;
          if (txCnt_reg == 11'(`EFFL_IFG_BYTES - 1)) begin
            txState_reg <= TX_IDLE;
          end
        end
        default: begin
          txState_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // byte chosen for the wire this tick
  always_comb begin
    unique case (txState_reg)
      TX_PRE: txByte = `EFFL_PREAMBLE_BYTE;
      TX_SFD: txByte = `EFFL_SFD_BYTE;
      TX_BODY: txByte = txValid ? txData : 8'h00;
      TX_PAD: txByte = 8'h00;
      TX_FCS: txByte = ~txCrc[8 * fcsIdx_reg +: 8];
      default: txByte = 8'h00;
    endcase
  end

  // crc covers only address through pad
  assign txCrcClr = tick && (txState_reg == TX_SFD);
  assign txCrcUpd = tick && (inBody || txState_reg == TX_PAD);

  effl_crc txCrcUnit (
    .clk(clk),
    .resetn(resetn),
    .clear(txCrcClr),
    .update(txCrcUpd),
    .data(txByte),
    .crc(txCrc)
  );

  // line outputs held in flops; idle and gap drive nothing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lineTxData <= 8'h00;
      lineTxEn <= 1'b0;
    end else if (tick) begin
      lineTxEn <= (txState_reg != TX_IDLE) && (txState_reg != TX_GAP);
      lineTxData <= txByte;
    end
  end

  // receive side: pin inputs pass two flops first
  logic dvMeta_reg;
  logic dvSync_reg;
  logic [7:0] rdMeta_reg;
  logic [7:0] rdSync_reg;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dvMeta_reg <= 1'b0;
      dvSync_reg <= 1'b0;
      rdMeta_reg <= 8'h00;
      rdSync_reg <= 8'h00;
    end else begin
      dvMeta_reg <= lineRxDv;
      dvSync_reg <= dvMeta_reg;
      rdMeta_reg <= lineRxData;
      rdSync_reg <= rdMeta_reg;
    end
  end

  // one strobe per byte while valid is high, paced like transmit
  logic rxTick;
  logic dvPrev_reg;
  logic frameEnd;
  assign rxTick = dvSync_reg && tick;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dvPrev_reg <= 1'b0;
    end else begin
      dvPrev_reg <= dvSync_reg;
    end
  end
  assign frameEnd = dvPrev_reg && !dvSync_reg;

  effl_rx_e rxState_reg;
  logic [10:0] rxCnt_reg;
  logic [31:0] rxCrc;
  logic rxCrcClr;
  logic rxCrcUpd;

  // hunt accepts any number of preamble bytes, even none
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxState_reg <= RX_HUNT;
      rxCnt_reg <= '0;
    end else if (frameEnd) begin
      rxState_reg <= RX_HUNT;
      rxCnt_reg <= '0;
    end else if (rxTick) begin
      unique case (rxState_reg)
        RX_HUNT: begin
          rxCnt_reg <= '0;
          if (rdSync_reg == `EFFL_SFD_BYTE) begin
            rxState_reg <= RX_DATA;
          end else if (rdSync_reg != `EFFL_PREAMBLE_BYTE) begin
            rxState_reg <= RX_DROP; // noise, wait for frame end
          end
        end
        RX_DATA: begin
          if (rxCnt_reg != 11'h7FF) begin
            rxCnt_reg <= rxCnt_reg + 11'd1;
          end
        end
        RX_DROP: begin
          rxState_reg <= RX_DROP;
        end
        default: begin
          rxState_reg <= RX_HUNT;
        end
      endcase
    end
  end

  assign rxCrcClr = rxTick && (rxState_reg == RX_HUNT);
  assign rxCrcUpd = rxTick && (rxState_reg == RX_DATA);

  effl_crc rxCrcUnit (
    .clk(clk),
    .resetn(resetn),
    .clear(rxCrcClr),
    .update(rxCrcUpd),
    .data(rdSync_reg),
    .crc(rxCrc)
  );

  // address kind, length/type, data stream out
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxValid <= 1'b0;
      rxData <= 8'h00;
      rxStart <= 1'b0;
      rxAddrKind <= DA_INDIV;
      rxLenType <= 16'h0000;
      rxIsType <= 1'b0;
    end else begin
      rxValid <= rxCrcUpd;
      rxData <= rdSync_reg;
      rxStart <= rxTick && (rxState_reg == RX_HUNT)
                 && (rdSync_reg == `EFFL_SFD_BYTE);
      if (rxCrcUpd && rxCnt_reg == 11'd0) begin
        // group bit is the first bit on the wire
        rxAddrKind <= rdSync_reg[0] ? DA_MULTI : DA_INDIV;
      end else if (rxCrcUpd && rxCnt_reg < 11'(`EFFL_ADDR_LEN)
                   && rdSync_reg != 8'hFF) begin
        if (rxAddrKind == DA_BCAST) begin
          rxAddrKind <= DA_MULTI;
        end
      end
      if (rxCrcUpd && rxCnt_reg == 11'd0 && rdSync_reg == 8'hFF) begin
        rxAddrKind <= DA_BCAST;
      end
      if (rxCrcUpd && rxCnt_reg == 11'(2 * `EFFL_ADDR_LEN)) begin
        rxLenType[15:8] <= rdSync_reg;
      end
      if (rxCrcUpd && rxCnt_reg == 11'(2 * `EFFL_ADDR_LEN + 1)) begin
        rxLenType[7:0] <= rdSync_reg;
        // values 1501..1535 are neither and read as length
        rxIsType <= {rxLenType[15:8], rdSync_reg} >= `EFFL_MIN_TYPE;
      end
    end
  end

  // verdict at frame end: residue check covers the received fcs too
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxGood <= 1'b0;
      rxBad <= 1'b0;
    end else begin
      rxGood <= frameEnd && (rxState_reg == RX_DATA)
                && (rxCrc == `EFFL_CRC_RESIDUE);
      rxBad <= frameEnd && (rxState_reg == RX_DATA)
               && (rxCrc != `EFFL_CRC_RESIDUE);
    end
  end
endmodule

// ==== testbench/effl_frame_checker.sv ====
// assertions on the frame logic ports
// assumes one clock per line byte
`timescale 1ns/100ps
module effl_frame_checker #(
  parameter int BYTE_CYCLES = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic txReady,
  input wire logic [7:0] lineTxData,
  input wire logic lineTxEn,
  input wire logic lineRxDv,
  input wire logic rxGood,
  input wire logic rxBad,
  input wire logic rxIsType,
  input wire logic [15:0] rxLenType
);
  logic [15:0] run_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // length of the current burst, so short frames show
  always_ff @(posedge clk) begin
    run_reg <= lineTxEn ? run_reg + 16'h0001 : 16'h0000;
  end
  sequence seqPre; (lineTxData == 8'hAA) [*7]; endsequence
  sequence seqSfd; lineTxData == 8'hAB; endsequence
  sequence seqIdle; !lineTxEn [*8] ##1 !lineTxEn [*4]; endsequence
  AST_PREAMBLE: assert property (
    $rose(lineTxEn) |-> seqPre) else $error("bad preamble");
  AST_SFD: assert property (
    $rose(lineTxEn) |-> seqPre ##1 seqSfd) else $error("bad delimiter");
  // the first user byte is taken while the delimiter is on the line
  AST_FIRST_TAKE: assert property (
    $rose(lineTxEn) |-> !txReady [*7] ##1 txReady)
    else $error("first byte not taken after delimiter");
  AST_PAD: assert property (
    $fell(lineTxEn) |-> int'(run_reg) >= 72 * BYTE_CYCLES)
    else $error("frame too short");
  AST_GAP: assert property (
    $fell(lineTxEn) |-> seqIdle) else $error("gap too short");
  AST_VERDICT: assert property (
    $fell(lineRxDv) |-> ##[1:8] (rxGood || rxBad))
    else $error("no frame verdict");
  AST_ONE_VERDICT: assert property (
    (rxGood || rxBad) |-> !(rxGood && rxBad) ##1 !(rxGood || rxBad))
    else $error("verdict not a single pulse");
  AST_TYPE: assert property (
    rxGood |-> rxIsType == (rxLenType >= 16'h0600))
    else $error("length or type misread");
endmodule
bind effl_frame effl_frame_checker #(.BYTE_CYCLES(BYTE_CYCLES)) chk (
  .clk, .resetn, .txReady, .lineTxData, .lineTxEn, .lineRxDv, .rxGood,
  .rxBad, .rxIsType, .rxLenType);

// ==== testbench/effl_phy_model.sv ====
// loopback phy: echoes line transmit bytes onto the receive pins
// assumes one byte per clock both ways
`timescale 1ns/100ps
module effl_phy_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] lineTxData,
  input wire logic lineTxEn,
  input wire logic skipPre,
  input wire logic corrupt,
  output logic lineRxDv,
  output logic [7:0] lineRxData
);
  int idx_reg;
  // echo a cycle late; idle data toggles so a stale byte never passes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idx_reg <= 0;
      lineRxDv <= 1'b0;
      lineRxData <= 8'h00;
    end else begin
      idx_reg <= lineTxEn ? idx_reg + 1 : 0;
      lineRxDv <= lineTxEn && !(skipPre && idx_reg < 7); // preamble lost
      if (!lineTxEn) lineRxData <= ~lineRxData;
      // hit the first byte after length/type, so that field stays intact
      else if (corrupt && idx_reg == 22) lineRxData <= ~lineTxData;
      else lineRxData <= lineTxData;
    end
  end
endmodule

// ==== testbench/effl_frame_tb.sv ====
// self-checking bench for the frame logic over a loopback phy
// assumes one clock per line byte
`timescale 1ns/100ps
module effl_frame_tb import effl_pkg::*;;
  logic clk = 0, resetn = 0, txValid = 0, txLast = 0;
  logic skipPre = 0, corrupt = 0;
  logic [7:0] txData = 8'h00;
  logic txReady, lineTxEn, lineRxDv, rxGood, rxBad, rxStart, rxIsType;
  logic [7:0] lineTxData, lineRxData;
  logic [1:0] rxAddrKind;
  logic [15:0] rxLenType;
  logic [2:0] saw;
  logic [7:0] txQ[$];
  logic rxValid;
  logic [7:0] rxData;
  logic [7:0] rxQ[$];
  int errorCnt = 0, nCompared = 0, cycles = 0;
  effl_frame #(.BYTE_CYCLES(1)) dut (.clk, .resetn, .txValid, .txData,
    .txLast, .txReady, .lineTxData, .lineTxEn, .lineRxDv, .lineRxData,
    .rxValid, .rxData, .rxStart, .rxGood, .rxBad, .rxAddrKind,
    .rxIsType, .rxLenType);
  effl_phy_model phy (.clk, .resetn, .lineTxData, .lineTxEn, .skipPre,
    .corrupt, .lineRxDv, .lineRxData);
  always #25 clk = ~clk;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic printVerdict();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // collect line bytes and receive pulses; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (lineTxEn === 1'b1) txQ.push_back(lineTxData);
    if (rxValid === 1'b1) rxQ.push_back(rxData);
    saw |= {rxStart === 1'b1, rxGood === 1'b1, rxBad === 1'b1};
    if (cycles > 5000) begin
      errorCnt++;
      printVerdict();
    end
  end
  // reflected crc, all-ones preset, complemented
  function automatic logic [31:0] fcs(input int last);
    logic [31:0] c = 32'hFFFF_FFFF;
    for (int i = 8; i < last; i++) begin
      c ^= {24'h00_0000, txQ[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
    end
    return ~c;
  endfunction
  // user byte i: address, fixed source, length/type, then a count
  function automatic logic [7:0] userByte(input logic [7:0] da,
                                          input logic [15:0] lt,
                                          input int i);
    return i < 6 ? da : i < 12 ? 8'h5A : i == 12 ? lt[15:8] :
           i == 13 ? lt[7:0] : 8'(i);
  endfunction
  // send one frame, wait for its verdict, judge the line image
  task automatic run_frame(input logic [7:0] da, input logic [15:0] lt,
                           input int n);
    int k;
    int m;
    txQ.delete();
    rxQ.delete();
    saw = 3'b000;
    for (int i = 0; i < 14 + n; i++) begin
      txData = userByte(da, lt, i);
      txValid = 1'b1;
      txLast = (i == 13 + n);
      k = 0;
      while (txReady !== 1'b1 && k < 300) begin
        step();
        k++;
      end
      if (k == 300) errorCnt++; // byte never taken
      step();
    end
    txValid = 1'b0;
    txLast = 1'b0;
    k = 0;
    while ((saw[1:0] == 2'b00 || lineTxEn !== 1'b0) && k < 300) begin
      step();
      k++;
    end
    if (k == 300) errorCnt++; // frame never judged
    m = txQ.size() - 4;
    for (int i = 0; i < 7; i++) check(txQ[i], 8'hAA);
    check(txQ[7], 8'hAB);
    for (int i = 0; i < m - 8; i++) begin
      check(txQ[i + 8], i < 14 + n ? userByte(da, lt, i) : 8'h00);
    end
    // receive stream carries every byte after the delimiter, fcs too
    check(rxQ.size(), m - 4);
    for (int i = 0; i < m - 4; i++) begin
      if (!corrupt || i != 14) check(rxQ[i], txQ[i + 8]);
    end
    check(m, n < 46 ? 68 : 22 + n);
    check({txQ[m+3], txQ[m+2], txQ[m+1], txQ[m]}, fcs(m));
    check(saw[2], 1'b1);
  endtask
  // broadcast, short data needing pad, protocol type
  task automatic t_bcast();
    run_frame(8'hFF, 16'h0800, 10);
    check(saw[1:0], 2'b10);
    check(rxAddrKind, DA_BCAST);
    check({rxIsType, rxLenType}, 17'h1_0800);
  endtask
  // multicast, largest length value, data exactly at minimum
  task automatic t_mcast();
    run_frame(8'h01, 16'h05DC, 46);
    check(saw[1:0], 2'b10);
    check(rxAddrKind, DA_MULTI);
    check({rxIsType, rxLenType}, 17'h0_05DC);
  endtask
  // individual, empty data, lowest type value, corrupted in flight
  task automatic t_bad();
    corrupt = 1'b1;
    run_frame(8'h02, 16'h0600, 0);
    corrupt = 1'b0;
    check(saw[1:0], 2'b01);
    check(rxAddrKind, DA_INDIV);
    check({rxIsType, rxLenType}, 17'h1_0600);
  endtask
  // preamble lost on the way in, frame still accepted
  task automatic t_nopre();
    skipPre = 1'b1;
    run_frame(8'h02, 16'h0800, 5);
    skipPre = 1'b0;
    check(saw[1:0], 2'b10);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_bcast();
    t_mcast();
    t_bad();
    t_nopre();
    printVerdict();
  end
endmodule
